// ---- src/bsrtc_defines.svh ----
// Constants for the bit-serial real-time clock, both link ends
`ifndef BSRTC_DEFINES_SVH
`define BSRTC_DEFINES_SVH
// ****************************************
// Device counter and address map
// ****************************************
`define BSRTC_CNT_W         14
`define BSRTC_PRESC_W       6
`define BSRTC_PRESC_LAST    6'h3f
`define BSRTC_ADDR_MODE     5'h00
`define BSRTC_ADDR_CLK_LO   5'h01
`define BSRTC_ADDR_CLK_HI   5'h0e
`define BSRTC_ADDR_ACK      5'h03
`define BSRTC_ADDR_STAT     5'h0f
`define BSRTC_CODE_RESET    4'h0
`define BSRTC_CODE_NONE     4'hf
`define BSRTC_SYNC_W        24
// ****************************************
// Host registers on APB
// ****************************************
`define BSRTC_REG_CMD       8'h00
`define BSRTC_REG_STATUS    8'h04
`define BSRTC_REG_CTRL      8'h08
`define BSRTC_CMD_DATA_BIT  8
`define BSRTC_CMD_WR_BIT    9
// ****************************************
// Host link timing in clock cycles
// ****************************************
`define BSRTC_SETUP_CYC     4'h4
`define BSRTC_STROBE_CYC    4'h4
`define BSRTC_HOLD_CYC      4'h4
`define BSRTC_READ_CYC      4'h8
`define BSRTC_RST_HOLD_CYC  4'h8
`endif

// ---- src/bsrtc_device.sv ----
// Device end: real-time clock, mode bit, event latch, interrupt code
`include "bsrtc_defines.svh"
module bsrtc_device (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  bsrtc_link_if.device     link,
  input  wire logic [15:1] interrupt_inputs_n_in,
  output logic             software_port_reset_out,
  output logic             timer_enabled_out,
  output logic             clock_mode_out
);
  // ****************************************
  // Helper functions
  // ****************************************
  // Address falls in the fourteen clock bits
  function automatic logic is_clock_bit(input logic [4:0] a);
    is_clock_bit = (a >= `BSRTC_ADDR_CLK_LO) && (a <= `BSRTC_ADDR_CLK_HI);
  endfunction
  // Address falls in bits 1 to 15
  function automatic logic is_low_bit(input logic [4:0] a);
    is_low_bit = (a >= `BSRTC_ADDR_CLK_LO) && (a <= `BSRTC_ADDR_STAT);
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [`BSRTC_SYNC_W-1:0] sync_s1;   // First stage, read by second only
  logic [`BSRTC_SYNC_W-1:0] sync_s2;   // Stable copy of pins
  logic                     strobe_d;  // Strobe one cycle later
  wire  [`BSRTC_SYNC_W-1:0] sync_raw = {interrupt_inputs_n_in,
                                        link.power_up_reset_n,
                                        link.serial_write_data,
                                        link.serial_write_strobe,
                                        link.chip_enable_n,
                                        link.bit_select};

  // Two flops on every outside input
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_s1  <= 24'hffffff;
      sync_s2  <= 24'hffffff;
      strobe_d <= 1'b1;
    end else begin
      sync_s1  <= sync_raw;
      sync_s2  <= sync_s1;
      strobe_d <= sync_s2[6];
    end
  end

  // Named views of the synchronised pins
  wire [4:0]  sel        = sync_s2[4:0];
  wire        ce_n_s     = sync_s2[5];
  wire        strobe_s   = sync_s2[6];
  wire        wdata_s    = sync_s2[7];
  wire        pur_active = ~sync_s2[8];
  wire [15:1] ints_n_s   = sync_s2[23:9];
  wire        third_interrupt_input = ~ints_n_s[3];

  // ****************************************
  // State
  // ****************************************
  logic                  mode;        // 0 interrupt, 1 clock
  logic [`BSRTC_PRESC_W-1:0] presc;   // Divide by 64
  bsrtc_pkg::bsrtc_count_t start;     // Programmed start value
  bsrtc_pkg::bsrtc_count_t next_start;// Start after a bit write
  bsrtc_pkg::bsrtc_count_t count;     // Live down-counter
  bsrtc_pkg::bsrtc_count_t latch;     // Event time latch
  logic                  clk_irq;     // Timer interrupt pending
  logic [15:1]           mask;        // Interrupt enables
  logic [3:0]            code;        // Registered level code
  logic                  req_n;       // Registered request
  logic                  rdata;       // Registered read datum
  logic                  rdata_oe;    // Read line driven
  logic                  soft_rst;    // Port reset pulse

  // ****************************************
  // Write decode
  // ****************************************
  wire write_take = strobe_s & ~strobe_d & ~ce_n_s;
  wire wr_mode    = write_take && (sel == `BSRTC_ADDR_MODE);
  wire wr_clk     = write_take && mode && is_clock_bit(sel);
  wire wr_mask    = write_take && !mode && is_low_bit(sel);
  wire wr_ack     = wr_mask && (sel == `BSRTC_ADDR_ACK);
  wire wr_soft    = write_take && mode && (sel == `BSRTC_ADDR_STAT)
                    && wdata_s;
  wire [3:0] clk_idx = 4'(sel - 5'h01);                            // Start bit index
  wire timer_en   = |start;
  wire tick       = (presc == `BSRTC_PRESC_LAST);
  wire wrap       = tick && timer_en && (count <= 14'h0001);

  // New start value with the addressed bit replaced
  always_comb begin
    next_start = start;
    if (wr_clk) begin
      next_start[clk_idx] = wdata_s;
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  // Free running so steps stay on terminal counts
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc <= '0;
    end else begin
      presc <= presc + 6'h01;
    end
  end

  // ****************************************
  // Mode bit and event latch
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode  <= 1'b0;
      latch <= '0;
    end else if (pur_active) begin
      mode  <= 1'b0;
    end else if (wr_mode) begin
      mode <= wdata_s;
      if (wdata_s) begin
        latch <= count;
      end
    end
  end

  // ****************************************
  // Start value and counter
  // ****************************************
  // Mode changes do not touch the counter
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start <= '0;
      count <= '0;
    end else if (pur_active) begin
      start <= '0;
      count <= '0;
    end else if (wr_clk) begin
      start <= next_start;
      count <= next_start;
    end else if (tick && timer_en) begin
      count <= wrap ? start : count - 14'h0001;
    end
  end

  // ****************************************
  // Timer interrupt flag
  // ****************************************
  // Set wins over an acknowledge in the same cycle
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_irq <= 1'b0;
    end else if (pur_active || !timer_en) begin
      clk_irq <= 1'b0;
    end else if (wrap) begin
      clk_irq <= 1'b1;
    end else if (wr_ack) begin
      clk_irq <= 1'b0;
    end
  end

  // ****************************************
  // Mask bits
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask <= '0;
    end else if (pur_active) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask[sel[3:0]] <= wdata_s;
    end
  end

  // ****************************************
  // Priority encoder
  // ****************************************
  logic [15:1] active;     // Enabled and asserted sources
  logic [3:0]  next_code;  // Highest priority level
  logic        next_req;   // Any source active
  always_comb begin
    active    = mask & ~ints_n_s;
    active[3] = mask[3] & (timer_en ? clk_irq : third_interrupt_input);
    next_code = `BSRTC_CODE_NONE;
    next_req  = 1'b0;
    for (int k = 15; k >= 1; k--) begin
      if (active[k]) begin
        next_code = 4'(k);
        next_req  = 1'b1;
      end
    end
  end

  // Code and request leave on a clock edge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      code  <= `BSRTC_CODE_RESET;
      req_n <= 1'b1;
    end else if (pur_active) begin
      code  <= `BSRTC_CODE_RESET;
      req_n <= 1'b1;
    end else begin
      code  <= next_code;
      req_n <= ~next_req;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [3:0] rd_idx = 4'(sel - 5'h01);        // Latch bit index
  wire rd_mode = (sel == `BSRTC_ADDR_MODE);
  wire rd_pin  = is_low_bit(sel) && ~ints_n_s[sel[3:0]];
  wire rd_clk  = is_clock_bit(sel) ? latch[rd_idx]
               : ((sel == `BSRTC_ADDR_STAT) && !req_n);
  wire rd_bit  = rd_mode ? mode
               : (mode ? rd_clk
               : rd_pin);

  // Addressed bit driven while enabled
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata    <= 1'b0;
      rdata_oe <= 1'b0;
    end else begin
      rdata    <= rd_bit;
      rdata_oe <= ~ce_n_s;
    end
  end

  // ****************************************
  // Software port reset pulse
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_soft | pur_active;
    end
  end

  // Outputs
  assign link.serial_read_data     = rdata;
  assign link.serial_read_data_oe  = rdata_oe;
  assign link.interrupt_level_code = code;
  assign link.interrupt_request_n  = req_n;
  assign software_port_reset_out   = soft_rst;
  assign timer_enabled_out         = timer_en;
  assign clock_mode_out            = mode;
endmodule // bsrtc_device

// ---- src/bsrtc_host.sv ----
// Host end: APB-driven sequencer for the bit-serial link
`include "bsrtc_defines.svh"
module bsrtc_host (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  bsrtc_link_if.host       link
);
  // ****************************************
  // State
  // ****************************************
  bsrtc_pkg::bsrtc_host_state_t state;  // Link sequencer
  logic [3:0]  cnt;         // Phase counter
  logic [4:0]  addr;        // Bit being accessed
  logic        wdat;        // Write datum
  logic        is_wr;       // Transfer is a write
  logic        rd_bit;      // Last read datum
  logic [3:0]  rst_cnt;     // Device reset hold
  logic [5:0]  s1;          // First sync stage
  logic [5:0]  s2;          // Second sync stage
  logic [31:0] rdata;       // Registered read data

  // ****************************************
  // APB decode
  // ****************************************
  wire access  = psel & penable;
  wire setup   = psel & ~penable;
  wire busy    = (state != bsrtc_pkg::BSRTC_IDLE);
  wire rst_bsy = (rst_cnt != 4'h0);
  wire cmd_go  = access && pwrite && (paddr == `BSRTC_REG_CMD) && !busy;
  wire rst_go  = access && pwrite && (paddr == `BSRTC_REG_CTRL) && pwdata[0];
  wire [31:0] status = {23'h0, rst_bsy, s2[4:1], 1'b0, ~s2[5], rd_bit, busy};
  wire [31:0] next_rdata = (paddr == `BSRTC_REG_STATUS) ? status : 32'h0;

  // Read word ready for the access phase
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata <= '0;
    end else if (setup) begin
      rdata <= next_rdata;
    end
  end
  assign prdata  = rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // Device pin synchronisers
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1 <= 6'h3e;
      s2 <= 6'h3e;
    end else begin
      s1 <= {link.interrupt_request_n, link.interrupt_level_code,
             link.serial_read_data};
      s2 <= s1;
    end
  end

  // ****************************************
  // Device power-up reset hold
  // ****************************************
  // Held low after own reset and on demand
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_cnt <= `BSRTC_RST_HOLD_CYC;
    end else if (rst_go) begin
      rst_cnt <= `BSRTC_RST_HOLD_CYC;
    end else if (rst_bsy) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  wire last = (cnt == 4'h1);
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state  <= bsrtc_pkg::BSRTC_IDLE;
      cnt    <= '0;
      addr   <= '0;
      wdat   <= 1'b0;
      is_wr  <= 1'b0;
      rd_bit <= 1'b0;
    end else begin
      case (state)
        bsrtc_pkg::BSRTC_IDLE: begin
          if (cmd_go) begin
            addr  <= pwdata[4:0];
            wdat  <= pwdata[`BSRTC_CMD_DATA_BIT];
            is_wr <= pwdata[`BSRTC_CMD_WR_BIT];
            cnt   <= `BSRTC_SETUP_CYC;
            state <= bsrtc_pkg::BSRTC_SETUP;
          end
        end
        bsrtc_pkg::BSRTC_SETUP: begin
          cnt <= cnt - 4'h1;
          if (last) begin
            cnt   <= is_wr ? `BSRTC_STROBE_CYC : `BSRTC_READ_CYC;
            state <= is_wr ? bsrtc_pkg::BSRTC_STROBE : bsrtc_pkg::BSRTC_READ;
          end
        end
        bsrtc_pkg::BSRTC_STROBE: begin
          cnt <= cnt - 4'h1;
          if (last) begin
            cnt   <= `BSRTC_HOLD_CYC;
            state <= bsrtc_pkg::BSRTC_HOLD;
          end
        end
        bsrtc_pkg::BSRTC_HOLD: begin
          cnt <= cnt - 4'h1;
          if (last) begin
            state <= bsrtc_pkg::BSRTC_IDLE;
          end
        end
        bsrtc_pkg::BSRTC_READ: begin
          cnt <= cnt - 4'h1;
          if (last) begin
            rd_bit <= s2[0];
            state  <= bsrtc_pkg::BSRTC_IDLE;
          end
        end
        default: begin
          state <= bsrtc_pkg::BSRTC_IDLE;
        end
      endcase
    end
  end

  // Link outputs
  assign link.bit_select          = addr;
  assign link.serial_write_data   = wdat;
  assign link.chip_enable_n       = ~busy;
  assign link.serial_write_strobe = (state == bsrtc_pkg::BSRTC_STROBE);
  assign link.power_up_reset_n    = ~rst_bsy;
endmodule // bsrtc_host

// ---- src/bsrtc_link_if.sv ----
// Bit-serial link between host and clock device
interface bsrtc_link_if;
  logic [4:0] bit_select;           // Addressed bit
  logic       chip_enable_n;        // Access enable, low active
  logic       serial_write_strobe;  // Write strobe, high active
  logic       serial_write_data;    // Write datum
  logic       serial_read_data;     // Read datum
  logic       serial_read_data_oe;  // Read datum driven
  logic       interrupt_request_n;  // Request, low active
  logic [3:0] interrupt_level_code; // Code, bit 3 is first code line
  logic       power_up_reset_n;     // Device reset, low active
  modport device (
    input  bit_select, chip_enable_n, serial_write_strobe, serial_write_data,
    input  power_up_reset_n,
    output serial_read_data, serial_read_data_oe,
    output interrupt_request_n, interrupt_level_code
  );
  modport host (
    output bit_select, chip_enable_n, serial_write_strobe, serial_write_data,
    output power_up_reset_n,
    input  serial_read_data, serial_read_data_oe,
    input  interrupt_request_n, interrupt_level_code
  );
endinterface

// ---- src/bsrtc_pkg.sv ----
// Types shared by the bit-serial real-time clock ends
package bsrtc_pkg;
  // Host link sequencer states
  typedef enum logic [2:0] {
    BSRTC_IDLE, BSRTC_SETUP, BSRTC_STROBE, BSRTC_HOLD, BSRTC_READ
  } bsrtc_host_state_t;
  // Timer count word
  typedef logic [13:0] bsrtc_count_t;
endpackage

// ---- tb/bsrtc_link_monitor.sv ----
// Concurrent checks on the bit-serial link between the two ends
module bsrtc_link_monitor (
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic [4:0] bit_select,
  input wire logic       chip_enable_n,
  input wire logic       serial_write_strobe,
  input wire logic       serial_write_data,
  input wire logic       serial_read_data,
  input wire logic       serial_read_data_oe,
  input wire logic       interrupt_request_n,
  input wire logic [3:0] interrupt_level_code,
  input wire logic       power_up_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Link assertions
  // ****************************************
  default clocking mon_cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // Strobe only inside an access
  AST_STROBE_CE: assert property (serial_write_strobe |-> !chip_enable_n)
    else $error("strobe outside access");
  // Strobe lasts four cycles
  AST_STROBE_WIDTH: assert property ($rose(serial_write_strobe) |->
    serial_write_strobe [*4] ##1 !serial_write_strobe) else $error("strobe width wrong");
  // Enable settles four cycles before strobe
  AST_SETUP_CE: assert property ($rose(serial_write_strobe) |-> $past(chip_enable_n, 4) == 1'b0)
    else $error("strobe setup too short");
  // Enable held four cycles after strobe
  AST_HOLD_CE: assert property ($fell(serial_write_strobe) |->
    !chip_enable_n [*4] ##1 chip_enable_n) else $error("strobe hold wrong");
  // Address and datum steady during an access
  AST_ADDR_HOLD: assert property (!chip_enable_n && !$past(chip_enable_n) |->
    $stable(bit_select) && $stable(serial_write_data)) else $error("address moved");
  // Read line driven only while selected
  AST_OE_ON: assert property (!chip_enable_n [*5] |-> serial_read_data_oe)
    else $error("read line not driven");
  AST_OE_OFF: assert property (chip_enable_n [*5] |-> !serial_read_data_oe)
    else $error("read line driven while idle");
  // Port addresses read zero
  AST_READ_PORT: assert property (!chip_enable_n [*5] ##0 bit_select[4] |->
    !serial_read_data) else $error("port address read nonzero");
  // Idle shows all ones or reset zero; a request shows a nonzero level, fifteen included
  AST_CODE_PAIR: assert property (interrupt_request_n ?
    (interrupt_level_code inside {4'h0, 4'hf}) : (interrupt_level_code != 4'h0))
    else $error("request and code disagree");
  // Held device reset forces code zero, request high
  AST_PUR_CODE: assert property (!power_up_reset_n [*5] |->
    interrupt_level_code == 4'h0 && interrupt_request_n) else $error("reset code wrong");
  // Device reset pulse from the host lasts at least two cycles
  AST_PUR_HOLD: assert property ($fell(power_up_reset_n) |->
    !power_up_reset_n [*2]) else $error("device reset pulse too short");
endmodule // bsrtc_link_monitor

// ---- tb/tb.sv ----
// Self-checking bench: APB host end driving the clock device end
`include "bsrtc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in;   // Bench clock
  logic        resetn_in;  // Bench reset
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;      // APB address
  logic [31:0] pwdata, prdata, rd;
  logic [15:1] pins_n;     // Interrupt pins, low active
  logic        sw_rst, timer_on, clk_mode, b;
  logic [13:0] lat;        // Event latch as read back
  int          n_fail, n_compared, cyc, n_sw, t0, i;
  // ****************************************
  // Clock, counters, design
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // Cycle count and count of cycles with port reset high
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (sw_rst === 1'b1) n_sw <= n_sw + 1;
  end
  bsrtc_link_if link_if ();
  bsrtc_device bsrtc_device_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .link(link_if.device), .interrupt_inputs_n_in(pins_n),
    .software_port_reset_out(sw_rst), .timer_enabled_out(timer_on), .clock_mode_out(clk_mode));
  bsrtc_host bsrtc_host_inst (.clock_in(clock_in), .resetn_in(resetn_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if.host));
  bsrtc_link_monitor bsrtc_link_monitor_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .bit_select(link_if.bit_select), .chip_enable_n(link_if.chip_enable_n),
    .serial_write_strobe(link_if.serial_write_strobe),
    .serial_write_data(link_if.serial_write_data),
    .serial_read_data(link_if.serial_read_data),
    .serial_read_data_oe(link_if.serial_read_data_oe),
    .interrupt_request_n(link_if.interrupt_request_n),
    .interrupt_level_code(link_if.interrupt_level_code),
    .power_up_reset_n(link_if.power_up_reset_n));
  // ****************************************
  // Tasks
  // ****************************************
  // One APB transfer; read data lands in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0, "bus error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  // One link bit transfer, waits until the host is idle
  task automatic link(input logic wr, input logic [4:0] a, input logic d);
    apb(1'b1, `BSRTC_REG_CMD, {22'h0, wr, d, 3'h0, a});
    do apb(1'b0, `BSRTC_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
    b = rd[1];
  endtask
  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Read one link bit and compare it
  task automatic rchk(input logic [4:0] a, input logic exp, input string m);
    link(1'b0, a, 1'b0);
    chk(b, exp, m);
  endtask
  // Wait for the request line, bounded
  task automatic wreq();
    for (int k = 0; k < 400 && link_if.interrupt_request_n !== 1'b0; k++) @(posedge clock_in);
  endtask
  // Wait for the host's device reset hold to end, then settle
  task automatic dev_reset();
    do apb(1'b0, `BSRTC_REG_STATUS, 32'h0); while (rd[8] !== 1'b0);
    repeat (4) @(posedge clock_in);
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Watchdog
  initial begin
    #100us;
    n_fail++;
    test_done();
  end
  initial begin
    resetn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins_n = 15'h7fff;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    dev_reset();
    chk(link_if.interrupt_level_code, 4'hf, "idle code");
    chk(timer_on, 1'b0, "timer off after reset");
    $display("reset test done");
    // Interrupt mode reads
    pins_n[5] <= 1'b0;
    rchk(5'h00, 1'b0, "mode bit");
    rchk(5'h05, 1'b1, "pin five low");
    rchk(5'h06, 1'b0, "pin six high");
    rchk(5'h10, 1'b0, "port address");
    pins_n[5] <= 1'b1;
    $display("interrupt mode read test done");
    // Timer start, request, acknowledge, period
    link(1'b1, 5'h03, 1'b1);
    link(1'b1, 5'h00, 1'b1);
    chk(clk_mode, 1'b1, "clock mode");
    rchk(5'h00, 1'b1, "mode bit set");
    pins_n[3] <= 1'b0;
    link(1'b1, 5'h02, 1'b1);
    chk(timer_on, 1'b1, "timer on");
    wreq();
    chk(link_if.interrupt_level_code, 4'h3, "timer level");
    rchk(5'h0f, 1'b1, "request status");
    link(1'b1, 5'h00, 1'b0);
    link(1'b1, 5'h03, 1'b1);
    chk(link_if.interrupt_request_n, 1'b1, "acknowledged, pin ignored");
    // Wrap to wrap; prescaler phase at a restart is arbitrary
    wreq();
    t0 = cyc;
    link(1'b1, 5'h03, 1'b1);
    wreq();
    chk(cyc - t0, 128, "timer period");
    $display("timer test done");
    // Event latch
    link(1'b1, 5'h00, 1'b1);
    for (i = 1; i <= 14; i++) begin
      link(1'b0, i[4:0], 1'b0);
      lat[i-1] = b;
    end
    chk(lat, 14'h2, "event latch");
    $display("event latch test done");
    // Software port reset
    t0 = n_sw;
    link(1'b1, 5'h0f, 1'b1);
    repeat (4) @(posedge clock_in);
    chk(n_sw - t0, 1, "port reset pulse");
    $display("port reset test done");
    // Zero start value disables, pin three returns
    link(1'b1, 5'h02, 1'b0);
    chk(timer_on, 1'b0, "zero start");
    repeat (6) @(posedge clock_in);
    chk(link_if.interrupt_level_code, 4'h3, "pin three level");
    pins_n[3] <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk(link_if.interrupt_level_code, 4'hf, "no request");
    $display("disable test done");
    // Device reset clears timer, mode and masks
    link(1'b1, 5'h02, 1'b1);
    apb(1'b1, `BSRTC_REG_CTRL, 32'h1);
    dev_reset();
    chk(timer_on, 1'b0, "reset timer");
    chk(clk_mode, 1'b0, "reset mode");
    pins_n[3] <= 1'b0;
    repeat (6) @(posedge clock_in);
    chk(link_if.interrupt_request_n, 1'b1, "masks cleared");
    $display("device reset test done");
    test_done();
  end
endmodule // tb
